// ==== hdl/ptp_tx_map.svh ====
// Register map, field positions and reset values of the transmit timestamp filter
`ifndef PTP_TX_MAP_SVH
`define PTP_TX_MAP_SVH
// ============================================================
// Summary of operation
// RULE1: With domain match on, only messages of the configured domain get stamped.
// RULE2: Bit 23, reset zero, switches on the domain number comparison.
// RULE3: Bit 22 set requires a zero alternate master flag for stamping.
// RULE4: Bit 21 clear drops stamps of bad UDP checksum frames; set ignores checksum.
// RULE5: Bit 20 clear drops stamps of bad FCS frames; set skips that check.
// RULE6: Four bit expected version, reset 2; zero accepts any version.
// RULE7: Stamp only types whose bit is set in a 16 bit mask, reset zero.
// RULE8: Software typically enables Sync, Delay_Req, Pdelay_Req and Pdelay_Resp.
// RULE9: Software keeps these fields still while timestamping is globally enabled.
// RULE10: Registers live in bank 2 and reach the port chosen by port select.
// RULE11: Bit 31 set clears the four reserved header bytes of modified frames.
// RULE12: Bit 30 set withholds stamps of frames whose correction field was adjusted.
// RULE13: Bit 29 set adds turnaround time into host Pdelay_Resp correction field.
// RULE14: Bit 28 set writes egress time into originTimestamp of host Sync messages.
// RULE15: Six bit offset, reset 010000b, locates the four reserved bytes to clear.
// RULE16: Six bit offset, reset 000101b, locates the ingress seconds byte.
// RULE17: Adjust correction field only for types set in a second mask, reset zero.
// RULE18: Save a stamp only when every enabled qualification check passes.

// ============================================================
// Register byte offsets
`define QUAL_CFG_OFS     9'h15C
`define MOD_CFG_OFS      9'h164
`define BANK_PORT_OFS    9'h0F0
`define PORT_BANK        3'h2
`define NUM_PORTS        3

// ============================================================
// Qualification word fields
`define Q_DOMAIN_HI      31
`define Q_DOMAIN_LO      24
`define Q_DOMAIN_ON      23
`define Q_ALT_ON         22
`define Q_UDP_BYPASS     21
`define Q_FCS_BYPASS     20
`define Q_VER_HI         19
`define Q_VER_LO         16
`define Q_QUAL_RST       32'h0002_0000

// ============================================================
// Modification word fields
`define M_CLR_RSVD       31
`define M_SUPPRESS       30
`define M_TURNAROUND     29
`define M_SYNC_ORIGIN    28
`define M_RSVD_HI        27
`define M_RSVD_LO        22
`define M_SEC_HI         21
`define M_SEC_LO         16
`define M_MOD_RST        32'h0405_0000

// ============================================================
// Bank and port select word fields
`define BP_BANK_HI       2
`define BP_BANK_LO       0
`define BP_PORT_HI       5
`define BP_PORT_LO       4
`define BP_STAMP_ON      8

// ============================================================
// Message types
`define MT_SYNC          4'h0
`define MT_PDELAY_RESP   4'h3
`endif

// ==== hdl/ptp_tx_pkg.sv ====
// Types shared by the transmit timestamp filter
`default_nettype none
package ptp_tx_pkg;
  // Header fields of one outgoing message, presented once per message
  typedef struct packed {
    logic [1:0] port;
    logic [3:0] msg_type;
    logic [3:0] version;
    logic [7:0] domain;
    logic       alt_primary;
    logic       udp_ok;
    logic       fcs_ok;
    logic       host_sent;
  } tx_desc_s;

  // Decision for that message
  typedef struct packed {
    logic       save;
    logic       adjust_cf;
    logic       turnaround_insert;
    logic       origin_insert;
    logic       clear_reserved;
    logic [5:0] reserved_offset;
    logic [5:0] seconds_offset;
  } tx_action_s;
endpackage
`default_nettype wire

// ==== hdl/tx_stamp_qualifier.sv ====
// Combinational decision for one outgoing message
`timescale 1ns/1ns
`default_nettype none
`include "ptp_tx_map.svh"
module tx_stamp_qualifier (
  // Configuration of the message's port
  input  wire logic [31:0]          qual_cfg_i,
  input  wire logic [31:0]          mod_cfg_i,
  input  wire logic                 stamp_on_i,
  // Message header
  input  wire ptp_tx_pkg::tx_desc_s desc_i,
  // Decision
  output var ptp_tx_pkg::tx_action_s action_o
);
  wire logic [3:0] exp_ver;
  wire logic       type_ok;
  wire logic       ver_ok;
  wire logic       dom_ok;
  wire logic       alt_ok;
  wire logic       udp_ok;
  wire logic       fcs_ok;
  wire logic       adjust;
  wire logic       turn;
  wire logic       origin;
  wire logic       modified;

  assign exp_ver  = qual_cfg_i[`Q_VER_HI:`Q_VER_LO];
  assign type_ok  = qual_cfg_i[desc_i.msg_type];                                   // [RULE7]
  assign ver_ok   = (exp_ver == 4'h0) || (exp_ver == desc_i.version);              // [RULE6]
  assign dom_ok   = !qual_cfg_i[`Q_DOMAIN_ON] ||
                    (qual_cfg_i[`Q_DOMAIN_HI:`Q_DOMAIN_LO] == desc_i.domain);      // [RULE1] [RULE2]
  assign alt_ok   = !qual_cfg_i[`Q_ALT_ON] || !desc_i.alt_primary;                 // [RULE3]
  assign udp_ok   = qual_cfg_i[`Q_UDP_BYPASS] || desc_i.udp_ok;                    // [RULE4]
  assign fcs_ok   = qual_cfg_i[`Q_FCS_BYPASS] || desc_i.fcs_ok;                    // [RULE5]

  assign adjust   = mod_cfg_i[desc_i.msg_type];                                    // [RULE17]
  assign turn     = mod_cfg_i[`M_TURNAROUND] && desc_i.host_sent &&
                    (desc_i.msg_type == `MT_PDELAY_RESP);                          // [RULE13]
  assign origin   = mod_cfg_i[`M_SYNC_ORIGIN] && desc_i.host_sent &&
                    (desc_i.msg_type == `MT_SYNC);                                 // [RULE14]
  assign modified = adjust || turn || origin;

  // Turnaround insertion also rewrites the correction field
  always_comb begin
    action_o.save              = stamp_on_i && type_ok && ver_ok && dom_ok && alt_ok &&
                                 udp_ok && fcs_ok &&
                                 !(mod_cfg_i[`M_SUPPRESS] && (adjust || turn)); // [RULE18] [RULE12]
    action_o.adjust_cf         = adjust || turn;
    action_o.turnaround_insert = turn;
    action_o.origin_insert     = origin;
    action_o.clear_reserved    = mod_cfg_i[`M_CLR_RSVD] && modified;               // [RULE11]
    action_o.reserved_offset   = mod_cfg_i[`M_RSVD_HI:`M_RSVD_LO];                 // [RULE15]
    action_o.seconds_offset    = mod_cfg_i[`M_SEC_HI:`M_SEC_LO];                   // [RULE16]
  end
endmodule // tx_stamp_qualifier
`default_nettype wire

// ==== hdl/ptp_tx_timestamp_filter.sv ====
// Transmit timestamp qualification and message modification, with Wishbone registers
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "ptp_tx_map.svh"
module ptp_tx_timestamp_filter (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [8:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic [31:0]               dat_o,
  output logic                      ack_o,
  // Egress message header from the frame path
  input  wire logic                 desc_valid_i,
  input  wire ptp_tx_pkg::tx_desc_s desc_i,
  // Decision toward the frame path
  output logic                      action_valid_o,
  output var ptp_tx_pkg::tx_action_s action_o
);
  // ============================================================
  // Storage
  logic [31:0]            qual_q [0:`NUM_PORTS-1];
  logic [31:0]            mod_q  [0:`NUM_PORTS-1];
  logic [2:0]             bank_q;
  logic [1:0]             port_q;
  logic                   stamp_on_q;
  logic                   ack_q;
  logic [31:0]            rdat_q;
  logic [31:0]            rdat_d;
  logic                   act_valid_q;
  ptp_tx_pkg::tx_action_s act_q;
  ptp_tx_pkg::tx_action_s act_d;

  // ============================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic port_exists(input logic [1:0] p);
    return ({30'h0000_0000, p} < 32'(`NUM_PORTS));
  endfunction

  // ============================================================
  // Bus decode
  wire logic        req;
  wire logic        wr;
  wire logic        hit_bp;
  wire logic        in_bank;
  wire logic        hit_qual;
  wire logic        hit_mod;
  wire logic [31:0] bp_word;
  wire logic [31:0] qual_sel;
  wire logic [31:0] mod_sel;

  assign req      = cyc_i && stb_i && !ack_q;
  assign wr       = req && we_i;
  assign hit_bp   = (adr_i == `BANK_PORT_OFS);
  // Port registers only answer with the port bank chosen and an existing port
  assign in_bank  = (bank_q == `PORT_BANK) && port_exists(port_q);                 // [RULE10]
  assign hit_qual = in_bank && (adr_i == `QUAL_CFG_OFS);                           // [RULE10]
  assign hit_mod  = in_bank && (adr_i == `MOD_CFG_OFS);                            // [RULE10]
  assign bp_word  = {23'h00_0000, stamp_on_q, 2'h0, port_q, 1'h0, bank_q};
  assign qual_sel = port_exists(port_q) ? qual_q[port_q] : 32'h0000_0000;
  assign mod_sel  = port_exists(port_q) ? mod_q[port_q]  : 32'h0000_0000;

  // Unmapped addresses still get an ack, reading zero
  always_comb begin
    if (hit_bp) begin
      rdat_d = bp_word;
    end else if (hit_qual) begin
      rdat_d = qual_sel;
    end else if (hit_mod) begin
      rdat_d = mod_sel;
    end else begin
      rdat_d = 32'h0000_0000;
    end
  end

  // ============================================================
  // Bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? rdat_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_q     <= 3'h0;
      port_q     <= 2'h0;
      stamp_on_q <= 1'b0;
    end else if (wr && hit_bp) begin
      if (sel_i[0]) begin
        bank_q <= dat_i[`BP_BANK_HI:`BP_BANK_LO];
        port_q <= dat_i[`BP_PORT_HI:`BP_PORT_LO];
      end
      if (sel_i[1]) begin
        stamp_on_q <= dat_i[`BP_STAMP_ON];
      end
    end
  end

  // Writes are steered to the selected port only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        qual_q[p] <= `Q_QUAL_RST;
        mod_q[p]  <= `M_MOD_RST;
      end
    end else begin
      if (wr && hit_qual) begin
        qual_q[port_q] <= merge(qual_q[port_q], dat_i, sel_i);                     // [RULE10]
      end
      if (wr && hit_mod) begin
        mod_q[port_q] <= merge(mod_q[port_q], dat_i, sel_i);                       // [RULE10]
      end
    end
  end

  assign dat_o = rdat_q;
  assign ack_o = ack_q;

  // ============================================================
  // Message path
  wire logic        desc_port_ok;
  wire logic [31:0] qual_msg;
  wire logic [31:0] mod_msg;

  assign desc_port_ok = port_exists(desc_i.port);
  // A message on a missing port sees all-zero configuration and is never stamped
  assign qual_msg = desc_port_ok ? qual_q[desc_i.port] : 32'h0000_0000;
  assign mod_msg  = desc_port_ok ? mod_q[desc_i.port]  : 32'h0000_0000;

  tx_stamp_qualifier u_qualifier (
    .qual_cfg_i (qual_msg),
    .mod_cfg_i  (mod_msg),
    .stamp_on_i (stamp_on_q),
    .desc_i     (desc_i),
    .action_o   (act_d)
  );

  // Decision is held until the next message replaces it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_valid_q <= 1'b0;
      act_q       <= '0;
    end else begin
      act_valid_q <= desc_valid_i;
      if (desc_valid_i) begin
        act_q <= act_d;
      end
    end
  end

  assign action_valid_o = act_valid_q;
  assign action_o       = act_q;

  // ============================================================
  // Checks
  sequence s_bus_req;
    cyc_i && stb_i && !ack_q;
  endsequence

  sequence s_ack_pulse;
    ack_q ##1 !ack_q;
  endsequence

  property p_bus_answer;
    @(posedge clk_i) disable iff (rst_i)
      s_bus_req |=> s_ack_pulse;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("Bus ack missing or too long"); // [RULE10]

  property p_domain;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i && qual_msg[`Q_DOMAIN_ON] &&
      (qual_msg[`Q_DOMAIN_HI:`Q_DOMAIN_LO] != desc_i.domain) |=> act_valid_q && !act_q.save;
  endproperty
  a_domain: assert property (p_domain) else $error("Stamp kept on foreign domain"); // [RULE1]

  property p_domain_off;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i && !qual_msg[`Q_DOMAIN_ON] && (qual_msg[`Q_VER_HI:`Q_VER_LO] == 4'h0) &&
      qual_msg[desc_i.msg_type] && qual_msg[`Q_UDP_BYPASS] && qual_msg[`Q_FCS_BYPASS] &&
      !qual_msg[`Q_ALT_ON] && !mod_msg[`M_SUPPRESS] && stamp_on_q |=> act_q.save;
  endproperty
  a_domain_off: assert property (p_domain_off) else $error("Open filter dropped a stamp"); // [RULE2]

  property p_alt;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i && qual_msg[`Q_ALT_ON] && desc_i.alt_primary |=> !act_q.save;
  endproperty
  a_alt: assert property (p_alt) else $error("Stamp kept with alternate flag"); // [RULE3]

  property p_udp;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i && !qual_msg[`Q_UDP_BYPASS] && !desc_i.udp_ok |=> !act_q.save;
  endproperty
  a_udp: assert property (p_udp) else $error("Stamp kept with bad checksum"); // [RULE4]

  property p_fcs;
    @(posedge clk_i) disable iff (rst_i)
      act_valid_q && act_q.save && !$past(qual_msg[`Q_FCS_BYPASS]) |-> $past(desc_i.fcs_ok);
  endproperty
  a_fcs: assert property (p_fcs) else $error("Stamp kept with bad frame check"); // [RULE5]

  property p_version;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i && (qual_msg[`Q_VER_HI:`Q_VER_LO] != 4'h0) &&
      (qual_msg[`Q_VER_HI:`Q_VER_LO] != desc_i.version) |=> !act_q.save;
  endproperty
  a_version: assert property (p_version) else $error("Stamp kept on wrong version"); // [RULE6]

  property p_type;
    @(posedge clk_i) disable iff (rst_i)
      act_valid_q && act_q.save |-> $past(qual_msg[desc_i.msg_type]) && $past(stamp_on_q);
  endproperty
  a_type: assert property (p_type) else $error("Stamp kept on disabled type"); // [RULE7] [RULE18]

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
      act_valid_q && act_q.clear_reserved |->
        $past(mod_msg[`M_CLR_RSVD]) && act_q.reserved_offset == $past(mod_msg[`M_RSVD_HI:`M_RSVD_LO]);
  endproperty
  a_clear: assert property (p_clear) else $error("Reserved clear without enable"); // [RULE11] [RULE15]

  property p_suppress;
    @(posedge clk_i) disable iff (rst_i)
      act_valid_q && act_q.adjust_cf && $past(mod_msg[`M_SUPPRESS]) |-> !act_q.save;
  endproperty
  a_suppress: assert property (p_suppress) else $error("Stamp kept on adjusted frame"); // [RULE12]

  property p_turnaround;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i && mod_msg[`M_TURNAROUND] && desc_i.host_sent &&
      (desc_i.msg_type == `MT_PDELAY_RESP) |=> act_q.turnaround_insert && act_q.adjust_cf;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("Turnaround not inserted"); // [RULE13]

  property p_origin;
    @(posedge clk_i) disable iff (rst_i)
      act_valid_q && act_q.origin_insert |->
        $past(mod_msg[`M_SYNC_ORIGIN]) && $past(desc_i.host_sent) && $past(desc_i.msg_type) == `MT_SYNC;
  endproperty
  a_origin: assert property (p_origin) else $error("Origin insert on wrong message"); // [RULE14]

  property p_seconds;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i |=> act_q.seconds_offset == $past(mod_msg[`M_SEC_HI:`M_SEC_LO]);
  endproperty
  a_seconds: assert property (p_seconds) else $error("Seconds offset not passed on"); // [RULE16]

  property p_adjust;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i && !mod_msg[desc_i.msg_type] && !mod_msg[`M_TURNAROUND] |=> !act_q.adjust_cf;
  endproperty
  a_adjust: assert property (p_adjust) else $error("Correction adjusted on masked type"); // [RULE17]

  property p_read_idle;
    @(posedge clk_i) disable iff (rst_i)
      !ack_q |-> rdat_q == 32'h0000_0000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("Read data outside ack"); // [RULE10]

  property p_bank_gate;
    @(posedge clk_i) disable iff (rst_i)
      req && !we_i && !in_bank && (adr_i == `QUAL_CFG_OFS) |=> rdat_q == 32'h0000_0000;
  endproperty
  a_bank_gate: assert property (p_bank_gate) else $error("Port register read outside bank"); // [RULE10]

  property p_action_pulse;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i |=> act_valid_q;
  endproperty
  a_action_pulse: assert property (p_action_pulse) else $error("Decision missing"); // [RULE18]

  property p_action_quiet;
    @(posedge clk_i) disable iff (rst_i)
      !desc_valid_i |=> !act_valid_q;
  endproperty
  a_action_quiet: assert property (p_action_quiet) else $error("Decision without message"); // [RULE18]

  property p_port_missing;
    @(posedge clk_i) disable iff (rst_i)
      desc_valid_i && !desc_port_ok |=> !act_q.save && !act_q.adjust_cf && !act_q.clear_reserved;
  endproperty
  a_port_missing: assert property (p_port_missing) else $error("Missing port acted on"); // [RULE10]

endmodule // ptp_tx_timestamp_filter
`default_nettype wire

// ==== test/egress_path_model.sv ====
// Behavioural egress frame path that hands message headers to the filter
`timescale 1ns/1ns
`default_nettype none
module egress_path_model (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Header toward the filter
  output logic                        desc_valid_o,
  output var ptp_tx_pkg::tx_desc_s    desc_o,
  // Decision from the filter
  input  wire logic                   action_valid_i,
  input  wire ptp_tx_pkg::tx_action_s action_i
);
  logic                   seen_q;
  ptp_tx_pkg::tx_action_s act_q;

  initial begin
    desc_valid_o = 1'b0;
    desc_o = '0;
  end

  // ============================================================
  // One header; decision sampled one cycle after it is taken
  task automatic send(input ptp_tx_pkg::tx_desc_s d, input int gap);
    repeat (gap) @(posedge clk_i);
    desc_valid_o <= 1'b1;
    desc_o <= d;
    @(posedge clk_i);
    desc_valid_o <= 1'b0;
    // Stale header inverted so a late sample cannot match by luck
    desc_o <= ~d;
    @(posedge clk_i);
    seen_q = action_valid_i;
    act_q = action_i;
  endtask
endmodule // egress_path_model
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the transmit timestamp filter
`timescale 1ns/1ns
`default_nettype none
`include "ptp_tx_map.svh"
module tb;
  logic                   clk_i;
  logic                   rst_i;
  logic                   cyc_i;
  logic                   stb_i;
  logic                   we_i;
  logic [8:0]             adr_i;
  logic [3:0]             sel_i;
  logic [31:0]            dat_i;
  logic [31:0]            dat_o;
  logic                   ack_o;
  logic                   desc_valid_i;
  ptp_tx_pkg::tx_desc_s   desc_i;
  logic                   action_valid_o;
  ptp_tx_pkg::tx_action_s action_o;
  logic [31:0]            rd;
  logic [31:0]            q_sh [4];
  logic [31:0]            m_sh [4];
  logic                   en;
  int                     miscompares;
  int                     checked;

  ptp_tx_timestamp_filter ptp_tx_timestamp_filter_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .desc_valid_i(desc_valid_i), .desc_i(desc_i),
    .action_valid_o(action_valid_o), .action_o(action_o));

  egress_path_model egress_path_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .desc_valid_o(desc_valid_i), .desc_o(desc_i),
    .action_valid_i(action_valid_o), .action_i(action_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ============================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task wb(input logic w, input logic [8:0] a, input logic [31:0] d,
          input logic [3:0] s, output logic [31:0] r);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    if (n >= 50) begin
      miscompares++;
      $display("[FAIL] %0t no bus acknowledge", $time);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task bp(input logic [1:0] p, input logic [2:0] b, input logic e);
    wb(1'b1, `BANK_PORT_OFS, {23'h0, e, 2'h0, p, 1'b0, b}, 4'hF, rd);
    en = e;
  endtask

  // Fields only change with stamping off, then stamping is turned back on
  task cfg(input logic [1:0] p, input logic [31:0] q, input logic [31:0] m);
    bp(p, `PORT_BANK, 1'b0);
    wb(1'b1, `QUAL_CFG_OFS, q, 4'hF, rd);
    wb(1'b1, `MOD_CFG_OFS, m, 4'hF, rd);
    q_sh[p] = q;
    m_sh[p] = m;
    bp(p, `PORT_BANK, 1'b1);
  endtask

  function automatic ptp_tx_pkg::tx_action_s ref_act(input ptp_tx_pkg::tx_desc_s d);
    ptp_tx_pkg::tx_action_s a;
    logic [31:0]            q;
    logic [31:0]            m;
    q = q_sh[d.port];
    m = m_sh[d.port];
    a.turnaround_insert = m[29] & d.host_sent & (d.msg_type == 4'h3);
    // Turnaround insertion rewrites the correction field too
    a.adjust_cf = m[d.msg_type] | a.turnaround_insert;
    a.origin_insert = m[28] & d.host_sent & (d.msg_type == 4'h0);
    a.clear_reserved = m[31] & (a.adjust_cf | a.turnaround_insert | a.origin_insert);
    a.reserved_offset = m[27:22];
    a.seconds_offset = m[21:16];
    a.save = en & q[d.msg_type] & (q[19:16] == 4'h0 || q[19:16] == d.version)
      & (!q[23] || q[31:24] == d.domain) & (!q[22] || !d.alt_primary)
      & (d.udp_ok | q[21]) & (d.fcs_ok | q[20])
      & !(m[30] & (a.adjust_cf | a.turnaround_insert));
    return a;
  endfunction

  // Flags are alternate flag, UDP ok, FCS ok, host sent
  task msg(input logic [1:0] p, input logic [3:0] t, input logic [3:0] v,
           input logic [7:0] dm, input logic [3:0] f);
    ptp_tx_pkg::tx_desc_s d;
    d = {p, t, v, dm, f};
    egress_path_model_i.send(d, t[0] ? 0 : 2);
    check({31'h0, egress_path_model_i.seen_q}, 32'h1);
    check({15'h0, egress_path_model_i.act_q}, {15'h0, ref_act(d)});
  endtask

  // ============================================================
  // Scenarios
  task t_reset;
    check({14'h0, action_valid_o, action_o}, 32'h0000_0000);
    check(dat_o, 32'h0000_0000);
    bp(2'h0, `PORT_BANK, 1'b0);
    wb(1'b0, `QUAL_CFG_OFS, 32'h0, 4'hF, rd);
    check(rd, 32'h0002_0000);
    wb(1'b0, `MOD_CFG_OFS, 32'h0, 4'hF, rd);
    check(rd, 32'h0405_0000);
    msg(2'h0, 4'h0, 4'h2, 8'h00, 4'h7);
  endtask

  task t_steer;
    for (int p = 0; p < 3; p++) begin
      cfg(2'(p), 32'h5A02_0100 | 32'(p), 32'h0405_1000 | 32'(p));
    end
    for (int p = 0; p < 3; p++) begin
      bp(2'(p), `PORT_BANK, 1'b0);
      wb(1'b0, `QUAL_CFG_OFS, 32'h0, 4'hF, rd);
      check(rd, q_sh[p]);
      wb(1'b0, `MOD_CFG_OFS, 32'h0, 4'hF, rd);
      check(rd, m_sh[p]);
    end
    bp(2'h0, 3'h1, 1'b0);
    wb(1'b0, `QUAL_CFG_OFS, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    bp(2'h3, `PORT_BANK, 1'b0);
    wb(1'b0, `QUAL_CFG_OFS, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    wb(1'b0, 9'h100, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    // Only byte lane 1 may change
    bp(2'h2, `PORT_BANK, 1'b0);
    wb(1'b1, `QUAL_CFG_OFS, 32'hFFFF_FFFF, 4'h2, rd);
    q_sh[2] = q_sh[2] | 32'h0000_FF00;
    wb(1'b0, `QUAL_CFG_OFS, 32'h0, 4'hF, rd);
    check(rd, q_sh[2]);
  endtask

  task t_types;
    cfg(2'h0, 32'h0002_000F, 32'h0405_0000);
    for (int t = 0; t < 16; t++) begin
      msg(2'h0, 4'(t), 4'h2, 8'h00, 4'h6);
    end
    bp(2'h0, `PORT_BANK, 1'b0);
    msg(2'h0, 4'h0, 4'h2, 8'h00, 4'h6);
  endtask

  task t_qualify;
    cfg(2'h0, 32'h5AC2_FFFF, 32'h0405_0000);
    msg(2'h0, 4'h1, 4'h2, 8'h5A, 4'h6);
    msg(2'h0, 4'h1, 4'h2, 8'h5B, 4'h6);
    msg(2'h0, 4'h1, 4'h2, 8'h5A, 4'hE);
    msg(2'h0, 4'h1, 4'h2, 8'h5A, 4'h2);
    msg(2'h0, 4'h1, 4'h2, 8'h5A, 4'h4);
    msg(2'h0, 4'h1, 4'h3, 8'h5A, 4'h6);
    cfg(2'h0, 32'h5A30_FFFF, 32'h0405_0000);
    msg(2'h0, 4'h2, 4'h7, 8'h5B, 4'h6);
    msg(2'h0, 4'h2, 4'h2, 8'h00, 4'hE);
    msg(2'h0, 4'h2, 4'h2, 8'h00, 4'h4);
    msg(2'h0, 4'h2, 4'h2, 8'h00, 4'h2);
  endtask

  task t_modify;
    cfg(2'h1, 32'h0002_FFFF, 32'hFA95_0002);
    msg(2'h1, 4'h1, 4'h2, 8'h00, 4'h6);
    msg(2'h1, 4'h3, 4'h2, 8'h00, 4'h7);
    msg(2'h1, 4'h0, 4'h2, 8'h00, 4'h7);
    msg(2'h1, 4'h0, 4'h2, 8'h00, 4'h6);
    msg(2'h1, 4'h3, 4'h2, 8'h00, 4'h6);
    cfg(2'h1, 32'h0002_FFFF, 32'hBA95_0002);
    msg(2'h1, 4'h1, 4'h2, 8'h00, 4'h6);
    msg(2'h3, 4'h1, 4'h2, 8'h00, 4'h6);
  endtask

  // ============================================================
  // Main sequence and watchdog
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 9'h000;
    sel_i = 4'h0;
    dat_i = 32'h0;
    en = 1'b0;
    miscompares = 0;
    checked = 0;
    for (int p = 0; p < 4; p++) begin
      q_sh[p] = (p < 3) ? 32'h0002_0000 : 32'h0;
      m_sh[p] = (p < 3) ? 32'h0405_0000 : 32'h0;
    end
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_steer();
    t_types();
    t_qualify();
    t_modify();
    results();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #40000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule // tb
`default_nettype wire
